// *** bench/pdo_props.sv ***
`timescale 1ns/1ps
module pdo_props
  import pdo_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  input wire logic divider_out_pin,
  input wire logic channel_match_irq
);
  // ****
  // helpers and properties
  // ****
  logic acc;
  logic mapped;
  logic [2:0] hist_r;
  assign acc = psel && penable;
  assign mapped = paddr inside {ctrl_off, compare_off, status_off, irq_enable_off, irq_clear_off, counter_off};
  // a control write may move the pin up to two cycles after it lands
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) hist_r <= 3'h0;
    else hist_r <= {hist_r[1:0], acc && pwrite && paddr == ctrl_off};
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  a_ready_always: assert property (psel |-> pready) else $error("pready low");
  a_err_unmapped: assert property (acc && !mapped |-> pslverr) else $error("no error on unmapped");
  a_err_mapped: assert property (acc && mapped |-> !pslverr) else $error("error on mapped");
  a_read_upper: assert property (acc && !pwrite |-> prdata[31:8] == 24'h00_0000) else $error("upper bits");
  a_clear_zero: assert property (acc && !pwrite && paddr == irq_clear_off |-> prdata == 32'h0000_0000)
    else $error("clear reads nonzero");
  a_pin_cause: assert property ($changed(divider_out_pin) |->
    (channel_match_irq || $past(channel_match_irq) || |hist_r) or ##1 channel_match_irq)
    else $error("pin moved without cause");
  a_match_toggle: assert property ($rose(channel_match_irq) |->
    divider_out_pin != $past(divider_out_pin, 2)) else $error("match without toggle");
  a_match_gap: assert property (channel_match_irq |=> !channel_match_irq [*8]) else $error("match too soon");
  c_match: cover property (channel_match_irq);
  c_pin_fall: cover property ($fell(divider_out_pin));
  c_err: cover property (acc && pslverr);
endmodule // pdo_props
bind pdo_timer pdo_props chk (.sys_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pready, .pslverr, .prdata,
  .divider_out_pin, .channel_match_irq);

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top
  import pdo_pkg::*;
;
  logic sys_clk, nrst, psel, penable, pwrite, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, divider_out_pin, channel_match_irq, irq;
  int errors, total_checks, n;
  pdo_timer uut (.sys_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
    .divider_out_pin, .channel_match_irq, .irq);
  // ****
  // shared tasks
  // ****
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      errors++;
      give_verdict();
    end
  endtask
  // counts cycles until the pin next changes; the level is taken half a cycle late so that
  // a level loaded by the write just before is not mistaken for a toggle
  task automatic wait_pin;
    logic p;
    @(negedge sys_clk);
    p = divider_out_pin;
    n = 1;
    do begin
      @(negedge sys_clk);
      n++;
    end while (divider_out_pin === p && n < 5000);
    if (n >= 5000) begin
      errors++;
      give_verdict();
    end
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_reset;
    check(divider_out_pin, 1'h1);
    check(irq, 1'h0);
    check(channel_match_irq, 1'h0);
    apb(0, ctrl_off, 0);
    check(rd, ctrl_rst);
    apb(0, compare_off, 0);
    check(rd, compare_rst);
    apb(0, 12'h020, 0);
    check(err, 1'h1);
    check(rd, 32'h0000_0000);
    $display("done reset");
  endtask
  task automatic t_slow;
    // the shared port latch lies outside this block, so the pin is watched directly
    apb(1, compare_off, 32'h0000_0001);
    apb(1, ctrl_off, 32'h0000_0011);
    repeat (100) @(negedge sys_clk);
    check(divider_out_pin, 1'h1);
    apb(0, counter_off, 0);
    check(rd, 32'h0000_0000);
    apb(1, ctrl_off, 32'h0000_0019);
    wait_pin();
    wait_pin();
    check(n, 2 * 128 * osc_div_cycles);
    wait_pin();
    check(n, 2 * 128 * osc_div_cycles);
    apb(1, ctrl_off, 32'h0000_0011);
    apb(0, counter_off, 0);
    check(rd, 32'h0000_0000);
    $display("done slow");
  endtask
  task automatic t_period;
    for (int c = 1; c <= 3; c += 2) begin
      apb(1, compare_off, c);
      apb(1, ctrl_off, 32'h0000_0069);
      wait_pin();
      wait_pin();
      check(n, (c + 1) * osc_div_cycles);
      wait_pin();
      check(n, (c + 1) * osc_div_cycles);
      apb(1, ctrl_off, 32'h0000_0061);
    end
    $display("done period");
  endtask
  task automatic t_irq;
    for (int e = 1; e >= 0; e--) begin
      apb(1, irq_enable_off, e);
      apb(1, ctrl_off, 32'h0000_0069);
      wait_pin();
      check(channel_match_irq, 1'h1);
      @(negedge sys_clk);
      check(channel_match_irq, 1'h0);
      apb(1, ctrl_off, 32'h0000_0061);
      apb(0, status_off, 0);
      check(rd[0], 1'h1);
      check(irq, e[0]);
      apb(1, irq_clear_off, 32'h0000_0001);
      apb(0, status_off, 0);
      check(rd[0], 1'h0);
      check(irq, 1'h0);
    end
    $display("done irq");
  endtask
  task automatic t_stop;
    logic p;
    apb(1, ctrl_off, 32'h0000_00e9);
    wait_pin();
    // the stopping write keeps bit 7, which now differs from the flip-flop
    apb(1, ctrl_off, 32'h0000_00e1);
    p = divider_out_pin;
    repeat (200) @(negedge sys_clk);
    check(divider_out_pin, p);
    apb(1, ctrl_off, 32'h0000_00e1);
    @(negedge sys_clk);
    check(divider_out_pin, 1'h0);
    apb(1, ctrl_off, 32'h0000_0061);
    @(negedge sys_clk);
    check(divider_out_pin, 1'h1);
    $display("done stop");
  endtask
  task automatic t_rerun;
    apb(1, ctrl_off, 32'h0000_0081);
    @(negedge sys_clk);
    check(divider_out_pin, 1'h0);
    @(posedge sys_clk);
    nrst <= 1'b0;
    @(negedge sys_clk);
    check(divider_out_pin, 1'h1);
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    apb(0, ctrl_off, 0);
    check(rd, ctrl_rst);
    check(divider_out_pin, 1'h1);
    $display("done rerun");
  endtask
  initial begin
    errors = 0;
    total_checks = 0;
    {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    t_reset();
    t_slow();
    t_period();
    t_irq();
    t_stop();
    t_rerun();
    give_verdict();
  end
endmodule // tb_top

// *** include/pdo_pkg.sv ***
package pdo_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [11:0] ctrl_off = 12'h000;
  localparam logic [11:0] compare_off = 12'h004;
  localparam logic [11:0] status_off = 12'h008;
  localparam logic [11:0] irq_enable_off = 12'h00c;
  localparam logic [11:0] irq_clear_off = 12'h010;
  localparam logic [11:0] counter_off = 12'h014;

  // ****************************************
  // control fields
  // ****************************************
  localparam int ctrl_ff_bit = 7;
  localparam int ctrl_run_bit = 3;
  localparam int ctrl_clk_lsb = 4;
  localparam int ctrl_mode_lsb = 0;
  localparam logic [2:0] clk_sel_div128 = 3'h1;
  localparam logic [2:0] mode_pdo = 3'h1;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] ctrl_rst = 8'h00;
  localparam logic [7:0] compare_rst = 8'hff;
  localparam logic [7:0] counter_rst = 8'h00;
  localparam logic ff_rst = 1'b0;

  // ****************************************
  // timing
  // ****************************************
  localparam int sys_clk_mhz = 200;
  localparam int main_osc_freq_mhz = 16;
  localparam int osc_div_cycles = sys_clk_mhz / main_osc_freq_mhz;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic ff_init;
    logic [2:0] clk_sel;
    logic run;
    logic [2:0] mode;
  } ctrl_s;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;
endpackage

// *** rtl/apb_regs.sv ***
`timescale 1ns/1ps
module apb_regs
  import pdo_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire apb_req_s req,
  input wire logic [7:0] status,
  input wire logic [7:0] counter,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  output logic [7:0] ctrl,
  output logic [7:0] compare,
  output logic [7:0] irq_enable,
  output logic ctrl_wr,
  output logic compare_wr,
  output logic irq_clear_wr,
  output logic [7:0] wdata
);
  // ****************************************
  // zero-wait slave, one word per register
  // ****************************************
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] compare;
    logic [7:0] irq_enable;
    logic [31:0] prdata;
  } reg_state_s;

  reg_state_s st_r;
  reg_state_s st_nxt;
  logic acc;
  logic known;

  always_comb begin
    st_nxt = st_r;
    acc = req.psel && !req.penable;
    known = 1'b1;
    ctrl_wr = 1'b0;
    compare_wr = 1'b0;
    irq_clear_wr = 1'b0;
    wdata = req.pwdata[7:0];
    case (req.paddr)
      ctrl_off: st_nxt.prdata = {24'h0000_00, st_r.ctrl};
      compare_off: st_nxt.prdata = {24'h0000_00, st_r.compare};
      status_off: st_nxt.prdata = {24'h0000_00, status};
      irq_enable_off: st_nxt.prdata = {24'h0000_00, st_r.irq_enable};
      irq_clear_off: st_nxt.prdata = 32'h0000_0000;
      counter_off: st_nxt.prdata = {24'h0000_00, counter};
      default: begin
        st_nxt.prdata = 32'h0000_0000;
        known = 1'b0;
      end
    endcase
    if (!acc) begin
      st_nxt.prdata = st_r.prdata;
    end
    if (req.psel && req.penable && req.pwrite) begin
      case (req.paddr)
        ctrl_off: begin
          st_nxt.ctrl = req.pwdata[7:0];
          ctrl_wr = 1'b1;
        end
        compare_off: begin
          // no shadow stage: used by the compare on the next cycle
          st_nxt.compare = req.pwdata[7:0];
          compare_wr = 1'b1;
        end
        irq_enable_off: st_nxt.irq_enable = req.pwdata[7:0];
        irq_clear_off: irq_clear_wr = 1'b1;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_r.ctrl <= ctrl_rst;
      st_r.compare <= compare_rst;
      st_r.irq_enable <= 8'h00;
      st_r.prdata <= 32'h0000_0000;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pready = 1'b1;
  assign pslverr = req.psel && req.penable && !known;
  assign prdata = st_r.prdata;
  assign ctrl = st_r.ctrl;
  assign compare = st_r.compare;
  assign irq_enable = st_r.irq_enable;
endmodule // apb_regs

// *** rtl/pdo_timer.sv ***
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
module pdo_timer
  import pdo_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  output logic divider_out_pin,
  output logic channel_match_irq,
  output logic irq
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0] count;
    logic ff;
    logic running;
    logic [7:0] status;
    logic match_q;
  } core_state_s;

  core_state_s st_r;
  core_state_s st_nxt;
  apb_req_s req;
  ctrl_s ctrl_f;
  logic [7:0] ctrl;
  logic [7:0] compare;
  logic [7:0] irq_enable;
  logic [7:0] wdata;
  logic ctrl_wr;
  logic compare_wr;
  logic irq_clear_wr;
  logic tick;
  logic match;
  logic pdo_mode;

  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
  assign ctrl_f = ctrl_s'(ctrl);

  // ****************************************
  // register slave and prescaler
  // ****************************************
  apb_regs u_regs (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .req(req),
    .status(st_r.status),
    .counter(st_r.count),
    .pready(pready),
    .pslverr(pslverr),
    .prdata(prdata),
    .ctrl(ctrl),
    .compare(compare),
    .irq_enable(irq_enable),
    .ctrl_wr(ctrl_wr),
    .compare_wr(compare_wr),
    .irq_clear_wr(irq_clear_wr),
    .wdata(wdata)
  );

  tick_divider u_div (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .clk_sel(ctrl_f.clk_sel),
    .tick(tick)
  );

  // ****************************************
  // counter and flip-flop
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    pdo_mode = (ctrl_f.mode == mode_pdo);
    st_nxt.running = ctrl_f.run && pdo_mode;
    // compare of zero is outside the legal range; it would match on every tick
    match = st_r.running && tick && (st_r.count == compare);
    if (st_r.running && tick) begin
      if (match) begin
        st_nxt.count = counter_rst;
        st_nxt.ff = ~st_r.ff;
      end else begin
        st_nxt.count = st_r.count + 8'h01;
      end
    end
    if (!st_r.running && !ctrl_f.run) begin
      // stopped: the level freezes until software loads bit 7 in a later write
      if (ctrl_wr) begin
        st_nxt.ff = wdata[ctrl_ff_bit];
        if (wdata[ctrl_run_bit]) begin
          // a start begins a fresh half period
          st_nxt.count = counter_rst;
        end
      end
    end else if (!st_r.running && ctrl_wr && wdata[ctrl_run_bit]) begin
      // start write also loads the initial level
      st_nxt.ff = wdata[ctrl_ff_bit];
      st_nxt.count = counter_rst;
    end
    // stopping freezes ff: no load in the stopping write
    if (irq_clear_wr) begin
      st_nxt.status = st_r.status & ~wdata;
    end
    if (match) begin
      st_nxt.status[0] = 1'b1;
    end
    st_nxt.match_q = match;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_r.count <= counter_rst;
      st_r.ff <= ff_rst;
      st_r.running <= 1'b0;
      st_r.status <= 8'h00;
      st_r.match_q <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign divider_out_pin = ~st_r.ff;
  assign channel_match_irq = st_r.match_q;
  assign irq = |(st_r.status & irq_enable);
endmodule // pdo_timer

// *** rtl/tick_divider.sv ***
`timescale 1ns/1ps
module tick_divider
  import pdo_pkg::*;
#(
  parameter int div_cycles = osc_div_cycles
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [2:0] clk_sel,
  output logic tick
);
  // ****************************************
  // main oscillator enable, then power-of-two prescaler
  // ****************************************
  typedef struct packed {
    logic [7:0] osc_cnt;
    logic [10:0] pre;
    logic tick;
  } div_state_s;

  div_state_s st_r;
  div_state_s st_nxt;
  logic osc_en;
  logic [10:0] pre_inc;

  always_comb begin
    st_nxt = st_r;
    osc_en = (st_r.osc_cnt == 8'(div_cycles - 1));
    pre_inc = st_r.pre + 11'h001;
    st_nxt.tick = 1'b0;
    if (osc_en) begin
      st_nxt.osc_cnt = 8'h00;
      st_nxt.pre = pre_inc;
      // tick when the selected bit of the prescaler rolls to zero; 6 ticks on every enable, 4 and 7 never tick
      case (clk_sel)
        3'h0: st_nxt.tick = (pre_inc == 11'h000);
        3'h1: st_nxt.tick = (pre_inc[6:0] == 7'h00);
        3'h2: st_nxt.tick = (pre_inc[4:0] == 5'h00);
        3'h3: st_nxt.tick = (pre_inc[2:0] == 3'h0);
        3'h5: st_nxt.tick = pre_inc[0] == 1'b0;
        3'h6: st_nxt.tick = 1'b1;
        default: st_nxt.tick = 1'b0;
      endcase
    end else begin
      st_nxt.osc_cnt = st_r.osc_cnt + 8'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;
endmodule // tick_divider
